//--- core/cfn_navigator.sv
// file tree navigator: select checks, current files and record pointer
module cfn_navigator
  import cfn_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           rst_b_i,
  input  wire logic           atr_i,
  input  wire logic           admin_i,
  input  wire logic           load_i,
  input  wire logic [2:0]     load_idx_i,
  input  wire cfn_hdr_t       load_hdr_i,
  input  wire logic           sel_i,
  input  wire logic [15:0]    sel_fid_i,
  input  wire logic           rec_i,
  input  wire cfn_rec_req_t   rec_req_i,
  input  wire logic           rec_done_i,
  input  wire logic           rec_abort_i,
  input  wire logic           bin_i,
  input  wire cfn_bin_req_t   bin_req_i,
  input  wire logic           app_i,
  input  wire logic [15:0]    app_dir_i,
  input  wire logic           hdr_req_i,
  output logic                sel_ok_o,
  output logic                sel_err_o,
  output logic                load_err_o,
  output logic                rec_ok_o,
  output logic                rec_err_o,
  output logic [7:0]          rec_target_o,
  output logic [15:0]         rec_offset_o,
  output logic                bin_ok_o,
  output logic                bin_err_o,
  output logic                app_ok_o,
  output logic [15:0]         cur_dir_o,
  output logic [15:0]         cur_file_o,
  output logic                file_valid_o,
  output logic [7:0]          rec_ptr_o,
  output cfn_hdr_t            hdr_o
);
  cfn_hdr_t        tbl_q [CFN_NFILES];
  logic [2:0]      dir_q, dir_d;
  logic [2:0]      file_q, file_d;
  logic            fvalid_q, fvalid_d;
  logic [2:0]      last_q, last_d;
  logic [7:0]      ptr_q, ptr_d;
  logic [7:0]      saved_q;
  logic            busy_q;
  logic            sel_ok_q, sel_err_q, load_err_q;
  logic            rec_ok_q, rec_err_q, bin_ok_q, bin_err_q, app_ok_q;
  logic [7:0]      rec_target_q;
  logic [15:0]     rec_offset_q;
  cfn_hdr_t        hdr_q;

  // identifier lookup: one match line per table entry
  logic [CFN_NFILES-1:0] hit;
  logic [CFN_NFILES-1:0] dup_sib;
  logic [CFN_NFILES-1:0] dup_anc;
  genvar g;
  generate
    for (g = 0; g < CFN_NFILES; g++) begin : g_match
      assign hit[g] = tbl_q[g].valid && (tbl_q[g].fid == sel_fid_i);
      // a load clashing with a sibling of the same parent
      assign dup_sib[g] = tbl_q[g].valid && (g != load_idx_i) &&
        (tbl_q[g].parent == load_hdr_i.parent) &&
        (tbl_q[g].fid == load_hdr_i.fid);
      // a load clashing with its parent or grandparent (tree depth two)
      assign dup_anc[g] = tbl_q[g].valid && (tbl_q[g].fid ==
        load_hdr_i.fid) && ((3'(g) == load_hdr_i.parent) ||
        (3'(g) == tbl_q[load_hdr_i.parent].parent));
    end
  endgenerate

  // priority encode the hits; ids may repeat across directories, so the lowest index wins
  logic [2:0] tgt;
  always_comb begin
    tgt = CFN_ROOT_IDX;
    for (int i = CFN_NFILES - 1; i >= 0; i--) begin
      if (hit[i]) tgt = 3'(i);
    end
  end

  wire        found     = |hit;
  wire [7:0]  tgt_type  = sel_fid_i[15:8];
  cfn_hdr_t   tgt_h;
  cfn_hdr_t   dir_h;
  cfn_hdr_t   file_h;
  assign tgt_h  = tbl_q[tgt];
  assign dir_h  = tbl_q[dir_q];
  assign file_h = tbl_q[file_q];

  // type byte tells a directory from a data file
  wire tgt_is_dir = (tgt_type == CFN_TYPE_ROOT) ||
                    (tgt_type == CFN_TYPE_DIR);
  wire tgt_is_data = (tgt_type == CFN_TYPE_DROOT) ||
                     (tgt_type == CFN_TYPE_DDIR);
  // data under the root must use 2F, under a directory 6F
  wire type_ok = tgt_is_dir ? (tgt_h.kind == CFN_ST_DIR) :
    tgt_is_data && (tgt_h.kind != CFN_ST_DIR) &&
    ((tgt_h.parent == CFN_ROOT_IDX) == (tgt_type == CFN_TYPE_DROOT));

  // allowed target set seen from the current directory
  wire is_child   = (tgt_h.parent == dir_q) && (tgt != dir_q);
  wire is_sibdir  = tgt_is_dir && (dir_q != CFN_ROOT_IDX) &&
                    (tgt_h.parent == dir_h.parent) && (tgt != dir_q);
  wire is_parent  = (tgt == dir_h.parent);
  wire is_self    = (tgt == dir_q);
  wire is_root    = (tgt == CFN_ROOT_IDX);
  wire is_last    = (tgt == last_q);
  wire sel_allow  = found && type_ok && (is_child || is_sibdir ||
    is_parent || is_self || is_root || is_last);

  // the record engine works on the current data file only
  wire rec_file = fvalid_q && ((file_h.kind == CFN_ST_LINEAR) ||
                               (file_h.kind == CFN_ST_CYCLIC));
  wire cyclic   = file_h.kind == CFN_ST_CYCLIC;
  logic [7:0] step_tgt;
  logic       step_ok;

  cfn_rec_step u_step (
    .ptr_i     (ptr_q),
    .cnt_i     (file_h.rec_cnt),
    .cyclic_i  (cyclic),
    .mode_i    (rec_req_i.mode),
    .rec_num_i (rec_req_i.rec_num),
    .target_o  (step_tgt),
    .ok_o      (step_ok)
  );

  // cyclic files accept updates only by stepping backwards
  // reads on a cyclic file may use any mode but the four seek modes
  wire upd_mode_ok = !cyclic || !rec_req_i.update ||
    (rec_req_i.mode == CFN_M_PREV);
  wire seek_mode = rec_req_i.mode[2];
  wire rec_accept = rec_i && !busy_q && rec_file && step_ok &&
    upd_mode_ok && !(seek_mode && rec_req_i.update) &&
    (file_h.rec_len != 8'h00);

  // cyclic update stores into the oldest slot, which then becomes
  // record one; the pointer rotates so record one stays newest
  wire [7:0] cyc_newest = (file_h.last_upd == file_h.rec_cnt) ?
    CFN_REC_FIRST : file_h.last_upd + 8'h01;

  // byte position of the chosen record, lengths fit in one byte
  wire [15:0] rec_off = 16'((step_tgt - 8'h01) * file_h.rec_len);

  // transparent body addressed from 0000 up to its stored length
  wire [16:0] bin_end = {1'b0, bin_req_i.offset} +
                        {9'h000, bin_req_i.count};
  wire bin_accept = bin_i && fvalid_q && (file_h.kind == CFN_ST_TRANSP)
    && (bin_req_i.offset >= CFN_BODY_FIRST)
    && (bin_end <= {1'b0, file_h.body_len});

  // reserved directory ids only for directories directly under the root
  wire load_rsv = (load_hdr_i.fid == CFN_TELECOM_ID ||
    load_hdr_i.fid == CFN_PRIMARY_ID || load_hdr_i.fid == CFN_SECOND_ID)
    && (load_hdr_i.kind != CFN_ST_DIR ||
        load_hdr_i.parent != CFN_ROOT_IDX);
  wire load_bad = (|dup_sib) || (|dup_anc) || load_rsv ||
    ((load_hdr_i.fid == CFN_ROOT_ID) != (load_idx_i == CFN_ROOT_IDX));
  wire load_take = load_i && admin_i && !load_bad;

  // next values of current directory, data file and pointer
  always_comb begin
    dir_d    = dir_q;
    file_d   = file_q;
    fvalid_d = fvalid_q;
    last_d   = last_q;
    ptr_d    = ptr_q;
    if (sel_i && sel_allow) begin
      last_d = tgt;
      if (tgt_h.kind == CFN_ST_DIR) begin
        dir_d    = tgt;
        fvalid_d = 1'b0;
        ptr_d    = CFN_PTR_NONE;
      end else begin
        file_d   = tgt;
        dir_d    = tgt_h.parent;
        fvalid_d = 1'b1;
        // record one is always the newest, so a cyclic file points there
        ptr_d    = (tgt_h.kind == CFN_ST_CYCLIC) ? CFN_REC_FIRST :
                   CFN_PTR_NONE;
      end
    end else if (rec_accept) begin
      ptr_d = (cyclic && rec_req_i.update) ? CFN_REC_FIRST : step_tgt;
    end else if (busy_q && rec_abort_i) begin
      ptr_d = saved_q;
    end
  end

  // header table storage, loadable only in the administrative phase; a cyclic update also writes last_upd
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < CFN_NFILES; i++) tbl_q[i] <= '0;
    end else if (load_take) begin
      tbl_q[load_idx_i] <= load_hdr_i;
    end else if (rec_accept && cyclic && rec_req_i.update) begin
      tbl_q[file_q].last_upd <= cyc_newest;
    end
  end

  // navigation state; answer-to-reset returns to the root
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dir_q    <= CFN_ROOT_IDX;
      file_q   <= CFN_ROOT_IDX;
      fvalid_q <= 1'b0;
      last_q   <= CFN_ROOT_IDX;
      ptr_q    <= CFN_PTR_NONE;
    end else if (atr_i) begin
      dir_q    <= CFN_ROOT_IDX;
      fvalid_q <= 1'b0;
      last_q   <= CFN_ROOT_IDX;
      ptr_q    <= CFN_PTR_NONE;
    end else begin
      dir_q    <= dir_d;
      file_q   <= file_d;
      fvalid_q <= fvalid_d;
      last_q   <= last_d;
      ptr_q    <= ptr_d;
    end
  end

  // a record action holds the old pointer until done, abort, a select or answer-to-reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_q  <= 1'b0;
      saved_q <= CFN_PTR_NONE;
    end else if (atr_i || sel_i) begin
      busy_q  <= 1'b0;
    end else if (rec_accept) begin
      busy_q  <= 1'b1;
      saved_q <= ptr_q;
    end else if (rec_done_i || rec_abort_i) begin
      busy_q  <= 1'b0;
    end
  end

  // registered answers, one cycle after each request
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_ok_q     <= 1'b0;
      sel_err_q    <= 1'b0;
      load_err_q   <= 1'b0;
      rec_ok_q     <= 1'b0;
      rec_err_q    <= 1'b0;
      rec_target_q <= 8'h00;
      rec_offset_q <= 16'h0000;
      bin_ok_q     <= 1'b0;
      bin_err_q    <= 1'b0;
      app_ok_q     <= 1'b0;
      hdr_q        <= '0;
    end else begin
      sel_ok_q   <= sel_i && !atr_i && sel_allow;
      sel_err_q  <= sel_i && !atr_i && !sel_allow;
      load_err_q <= load_i && !load_take;
      rec_ok_q   <= rec_accept && !atr_i && !sel_i;
      rec_err_q  <= rec_i && !rec_accept;
      bin_ok_q   <= bin_accept;
      bin_err_q  <= bin_i && !bin_accept;
      app_ok_q   <= app_i && (app_dir_i == dir_h.fid);
      if (rec_accept) begin
        rec_target_q <= step_tgt;
        rec_offset_q <= rec_off;
      end
      // returns the current file header when one is valid, else the directory
      if (hdr_req_i) hdr_q <= fvalid_q ? file_h : dir_h;
    end
  end

  assign sel_ok_o     = sel_ok_q;
  assign sel_err_o    = sel_err_q;
  assign load_err_o   = load_err_q;
  assign rec_ok_o     = rec_ok_q;
  assign rec_err_o    = rec_err_q;
  assign rec_target_o = rec_target_q;
  assign rec_offset_o = rec_offset_q;
  assign bin_ok_o     = bin_ok_q;
  assign bin_err_o    = bin_err_q;
  assign app_ok_o     = app_ok_q;
  assign cur_dir_o    = dir_h.fid;
  assign cur_file_o   = fvalid_q ? file_h.fid : 16'h0000;
  assign file_valid_o = fvalid_q;
  assign rec_ptr_o    = ptr_q;
  assign hdr_o        = hdr_q;

  // a rejected select leaves the navigation state alone
  property p_reject_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
    (sel_i && !sel_allow && !atr_i) |=> ($stable(dir_q) &&
      $stable(fvalid_q) && $stable(ptr_q));
  endproperty
  a_reject_keeps_state: assert property (p_reject_hold)
    else $error("rejected select changed state");

  a_atr_root_dir: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) atr_i |=> (dir_q == CFN_ROOT_IDX && !fvalid_q))
    else $error("root not current after reset");

  a_dir_sel_nofile: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) (sel_i && sel_allow && !atr_i &&
    tgt_h.kind == CFN_ST_DIR) |=> !fvalid_q ##1 1'b1)
    else $error("data file survived directory select");

  a_file_child_dir: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) fvalid_q |-> (file_h.parent == dir_q))
    else $error("current file not child of directory");

  a_lin_ptr_clear: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) (sel_i && sel_allow && !atr_i &&
    tgt_h.kind == CFN_ST_LINEAR) |=> (ptr_q == CFN_PTR_NONE))
    else $error("linear pointer not cleared");

  a_cyc_ptr_last: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) (sel_i && sel_allow && !atr_i &&
    tgt_h.kind == CFN_ST_CYCLIC) |=> (ptr_q == CFN_REC_FIRST))
    else $error("cyclic pointer not at last update");

  sequence s_rec_start;
    rec_accept && !atr_i && !sel_i;
  endsequence
  sequence s_abort;
    busy_q && rec_abort_i && !sel_i && !atr_i;
  endsequence
  a_abort_restore: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) s_abort |=> (ptr_q == $past(saved_q)))
    else $error("abort did not restore pointer");

  a_linear_nowrap: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) (s_rec_start and (!cyclic &&
    rec_req_i.mode == CFN_M_NEXT && ptr_q == file_h.rec_cnt)) |-> 1'b0)
    else $error("linear next past last record");

  a_cyc_upd_prev: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) (rec_accept && cyclic && rec_req_i.update)
    |-> rec_req_i.mode == CFN_M_PREV)
    else $error("cyclic update not previous mode");

  a_app_dir_match: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) app_ok_q |-> $past(app_dir_i == dir_h.fid))
    else $error("application command outside directory");
endmodule // cfn_navigator

//--- core/cfn_pkg.sv
// package of constants and types for the card file system navigator
package cfn_pkg;
  // file identifier type codes carried in the high byte
  localparam logic [7:0] CFN_TYPE_ROOT = 8'h3F;
  localparam logic [7:0] CFN_TYPE_DIR  = 8'h7F;
  localparam logic [7:0] CFN_TYPE_DROOT = 8'h2F;
  localparam logic [7:0] CFN_TYPE_DDIR = 8'h6F;
  localparam logic [15:0] CFN_ROOT_ID  = 16'h3F00;
  localparam logic [15:0] CFN_TELECOM_ID = 16'h7F10;
  localparam logic [15:0] CFN_PRIMARY_ID = 16'h7F20;
  localparam logic [15:0] CFN_SECOND_ID  = 16'h7F21;
  localparam logic [15:0] CFN_BODY_FIRST = 16'h0000;
  localparam logic [7:0]  CFN_REC_FIRST  = 8'h01;
  localparam logic [7:0]  CFN_PTR_NONE   = 8'h00;
  localparam logic [7:0]  CFN_REC_MAX    = 8'hFF;
  localparam int          CFN_NFILES     = 8;
  localparam int          CFN_IDXW       = 3;
  localparam logic [2:0]  CFN_ROOT_IDX   = 3'h0;

  // structure of a file body
  typedef enum logic [1:0] {
    CFN_ST_DIR = 2'b00,
    CFN_ST_TRANSP = 2'b01,
    CFN_ST_LINEAR = 2'b10,
    CFN_ST_CYCLIC = 2'b11
  } cfn_struct_t;

  // record access modes
  typedef enum logic [2:0] {
    CFN_M_ABS   = 3'b000,
    CFN_M_NEXT  = 3'b001,
    CFN_M_PREV  = 3'b010,
    CFN_M_CURR  = 3'b011,
    CFN_M_SFIRST = 3'b100,
    CFN_M_SNEXT  = 3'b101,
    CFN_M_SLAST  = 3'b110,
    CFN_M_SPREV  = 3'b111
  } cfn_mode_t;

  // per-file header as held by the card
  typedef struct packed {
    logic        valid;
    logic [15:0] fid;
    logic [2:0]  parent;
    cfn_struct_t kind;
    logic [7:0]  rec_len;
    logic [7:0]  rec_cnt;
    logic [15:0] body_len;
    logic [7:0]  last_upd;
  } cfn_hdr_t;

  // record access request
  typedef struct packed {
    cfn_mode_t  mode;
    logic       update;
    logic [7:0] rec_num;
  } cfn_rec_req_t;

  // binary access request
  typedef struct packed {
    logic [15:0] offset;
    logic [7:0]  count;
  } cfn_bin_req_t;
endpackage : cfn_pkg

//--- core/cfn_rec_step.sv
// record pointer step computation for record files
module cfn_rec_step
  import cfn_pkg::*;
(
  input  wire logic [7:0] ptr_i,
  input  wire logic [7:0] cnt_i,
  input  wire logic       cyclic_i,
  input  wire cfn_mode_t  mode_i,
  input  wire logic [7:0] rec_num_i,
  output logic [7:0]      target_o,
  output logic            ok_o
);
  wire ptr_set  = (ptr_i != CFN_PTR_NONE);
  wire at_last  = (ptr_i == cnt_i);
  wire at_first = (ptr_i == CFN_REC_FIRST);
  wire [7:0] nxt = ptr_i + 8'h01;
  wire [7:0] prv = ptr_i - 8'h01;

  // pick the addressed record; a zero count means an empty file
  always_comb begin
    target_o = CFN_PTR_NONE;
    ok_o     = 1'b0;
    unique case (mode_i)
      CFN_M_ABS: begin
        target_o = rec_num_i;
        ok_o = (rec_num_i != CFN_PTR_NONE) && (rec_num_i <= cnt_i);
      end
      CFN_M_NEXT: begin
        if (!ptr_set) target_o = CFN_REC_FIRST;
        else if (at_last) target_o = cyclic_i ? CFN_REC_FIRST : ptr_i;
        else target_o = nxt;
        ok_o = !ptr_set || !at_last || cyclic_i;
      end
      CFN_M_PREV: begin
        if (!ptr_set) target_o = cnt_i;
        else if (at_first) target_o = cyclic_i ? cnt_i : ptr_i;
        else target_o = prv;
        ok_o = !ptr_set || !at_first || cyclic_i;
      end
      CFN_M_CURR: begin
        target_o = ptr_i;
        ok_o = ptr_set;
      end
      CFN_M_SFIRST: begin
        target_o = CFN_REC_FIRST;
        ok_o = !cyclic_i;
      end
      CFN_M_SNEXT: begin
        target_o = nxt;
        ok_o = !cyclic_i && ptr_set && !at_last;
      end
      CFN_M_SLAST: begin
        target_o = cnt_i;
        ok_o = !cyclic_i;
      end
      CFN_M_SPREV: begin
        target_o = prv;
        ok_o = !cyclic_i && ptr_set && !at_first;
      end
    endcase
    if (cnt_i == CFN_PTR_NONE) ok_o = 1'b0;
  end
endmodule // cfn_rec_step

//--- tb/cfn_term_model.sv
// terminal-side model that issues file requests to the navigator
module cfn_term_model
  import cfn_pkg::*;
(
  input  wire logic    clk_i,
  output logic         atr_o,
  output logic         sel_o,
  output logic [15:0]  sel_fid_o,
  output logic         rec_o,
  output cfn_rec_req_t rec_req_o,
  output logic         done_o,
  output logic         abort_o,
  output logic         bin_o,
  output cfn_bin_req_t bin_req_o,
  output logic         app_o,
  output logic [15:0]  app_dir_o,
  output logic         hdr_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // pending request data, filled in by the bench before each request
  logic [15:0]  fid_n;
  cfn_rec_req_t rq_n;
  cfn_bin_req_t bq_n;
  logic [15:0]  dir_n;

  // all strobes idle from time zero
  initial begin
    {atr_o, sel_o, rec_o, done_o, abort_o, bin_o, app_o, hdr_o} = '0;
    sel_fid_o = '0;
    rec_req_o = '0;
    bin_req_o = '0;
    app_dir_o = '0;
  end

  // one request: strobe and data for exactly one cycle, then released
  task automatic fire(input int k);
    @(posedge clk_i);
    sel_fid_o <= fid_n;
    rec_req_o <= rq_n;
    bin_req_o <= bq_n;
    app_dir_o <= dir_n;
    // strobes decoded from the request kind, one of them high
    atr_o   <= (k == 0);
    sel_o   <= (k == 1);
    rec_o   <= (k == 2);
    done_o  <= (k == 3);
    abort_o <= (k == 4);
    bin_o   <= (k == 5);
    app_o   <= (k == 6);
    hdr_o   <= (k >= 7);
    @(posedge clk_i);
    {atr_o, sel_o, rec_o, done_o, abort_o, bin_o, app_o, hdr_o} <= '0;
    // released data is inverted so a stale value is never mistaken for live
    sel_fid_o <= ~sel_fid_o;
    rec_req_o <= cfn_rec_req_t'(~rec_req_o);
    bin_req_o <= ~bin_req_o;
    app_dir_o <= ~app_dir_o;
    #1;
  endtask
endmodule // cfn_term_model

//--- tb/tb_card_file_system_navigator.sv
// self-checking bench for the card file system navigator
`define CHK(a, b) begin \
  tests_run++; \
  if ((a) !== (b)) begin \
    n_fail++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); \
  end \
end
module tb_card_file_system_navigator
  import cfn_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i, rst_b_i, admin_i, load_i, atr_i, sel_i, rec_i;
  logic rec_done_i, rec_abort_i, bin_i, app_i, hdr_req_i;
  logic [2:0]   load_idx_i;
  cfn_hdr_t     load_hdr_i, hdr_o, ht[7], tmp;
  logic [15:0]  sel_fid_i, app_dir_i, cur_dir_o, cur_file_o, rec_offset_o;
  cfn_rec_req_t rec_req_i;
  cfn_bin_req_t bin_req_i;
  logic sel_ok_o, sel_err_o, load_err_o, rec_ok_o, rec_err_o, bin_ok_o;
  logic bin_err_o, app_ok_o, file_valid_o;
  logic [7:0]   rec_target_o, rec_ptr_o;
  logic [15:0]  tf[8], e_dir, e_file, e_last;
  int           tp[8], n_fail, tests_run;
  bit           td[8];
  int           seed = 36576;

  cfn_navigator dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .atr_i(atr_i),
    .admin_i(admin_i), .load_i(load_i), .load_idx_i(load_idx_i),
    .load_hdr_i(load_hdr_i), .sel_i(sel_i), .sel_fid_i(sel_fid_i),
    .rec_i(rec_i), .rec_req_i(rec_req_i), .rec_done_i(rec_done_i),
    .rec_abort_i(rec_abort_i), .bin_i(bin_i), .bin_req_i(bin_req_i),
    .app_i(app_i), .app_dir_i(app_dir_i), .hdr_req_i(hdr_req_i),
    .sel_ok_o(sel_ok_o), .sel_err_o(sel_err_o), .load_err_o(load_err_o),
    .rec_ok_o(rec_ok_o), .rec_err_o(rec_err_o),
    .rec_target_o(rec_target_o), .rec_offset_o(rec_offset_o),
    .bin_ok_o(bin_ok_o), .bin_err_o(bin_err_o), .app_ok_o(app_ok_o),
    .cur_dir_o(cur_dir_o), .cur_file_o(cur_file_o),
    .file_valid_o(file_valid_o), .rec_ptr_o(rec_ptr_o), .hdr_o(hdr_o));

  cfn_term_model term (.clk_i(clk_i), .atr_o(atr_i), .sel_o(sel_i),
    .sel_fid_o(sel_fid_i), .rec_o(rec_i), .rec_req_o(rec_req_i),
    .done_o(rec_done_i), .abort_o(rec_abort_i), .bin_o(bin_i),
    .bin_req_o(bin_req_i), .app_o(app_i), .app_dir_o(app_dir_i),
    .hdr_o(hdr_req_i));

  // 10 MHz clock
  always #50 clk_i = ~clk_i;

  task automatic tally_and_finish;
    if (n_fail == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // header loads happen card-side, so the bench drives them directly
  task automatic load(input int i, input cfn_hdr_t h, input logic err);
    @(posedge clk_i);
    load_i <= 1'b1;
    load_idx_i <= i[2:0];
    load_hdr_i <= h;
    @(posedge clk_i);
    load_i <= 1'b0;
    #1;
    `CHK(load_err_o, err)
  endtask

  // expected select outcome from the tree and the current state
  function automatic bit allowed(logic [15:0] t);
    int i, c;
    i = -1;
    c = 0;
    for (int k = 0; k < 7; k++) begin
      if (tf[k] == t) i = k;
      if (tf[k] == e_dir) c = k;
    end
    if (i < 0) return 1'b0;
    return i == 0 || i == c || i == tp[c] || (tp[i] == c && i != 0) ||
           (td[i] && tp[i] == tp[c]) || t == e_last;
  endfunction

  task automatic sel(input logic [15:0] t);
    bit ok;
    ok = allowed(t);
    term.fid_n = t;
    term.fire(1);
    `CHK(sel_ok_o, ok)
    `CHK(sel_err_o, !ok)
    for (int k = 0; k < 7; k++) begin
      if (ok && tf[k] == t) begin
        e_last = t;
        e_dir = td[k] ? t : e_dir;
        e_file = td[k] ? 16'h0000 : t;
      end
    end
    `CHK(cur_dir_o, e_dir)
    `CHK(cur_file_o, e_file)
    `CHK(file_valid_o, e_file != 16'h0000)
  endtask

  // accepted actions are closed with done so the next may start
  task automatic rec(input cfn_mode_t m, input logic u, input logic [7:0] n,
                     input logic ok, input logic [7:0] tg);
    term.rq_n = '{m, u, n};
    term.fire(2);
    `CHK(rec_ok_o, ok)
    `CHK(rec_err_o, !ok)
    if (ok) begin
      if (!u) `CHK(rec_target_o, tg)
      `CHK(rec_ptr_o, tg)
      term.fire(3);
    end
  endtask

  task automatic bin(input logic [15:0] o, input logic [7:0] c);
    term.bq_n = '{o, c};
    term.fire(5);
    `CHK(bin_ok_o, (int'(o) + int'(c)) <= 16)
    `CHK(bin_err_o, (int'(o) + int'(c)) > 16)
  endtask

  task automatic atr;
    term.fire(0);
    e_dir = CFN_ROOT_ID;
    e_file = 16'h0000;
    e_last = CFN_ROOT_ID;
    `CHK(cur_dir_o, CFN_ROOT_ID)
    `CHK(file_valid_o, 1'b0)
  endtask

  // watchdog sized well above the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    tally_and_finish;
  end

  initial begin
    {clk_i, rst_b_i, admin_i, load_i} = '0;
    load_idx_i = '0;
    load_hdr_i = '0;
    ht[0] = '{1'b1, 16'h3F00, 3'd0, CFN_ST_DIR, 8'h00, 8'h00, 16'h0000, 8'h00};
    ht[1] = '{1'b1, 16'h7F10, 3'd0, CFN_ST_DIR, 8'h00, 8'h00, 16'h0000, 8'h00};
    ht[2] = '{1'b1, 16'h7F20, 3'd0, CFN_ST_DIR, 8'h00, 8'h00, 16'h0000, 8'h00};
    ht[3] = '{1'b1, 16'h2F05, 3'd0, CFN_ST_TRANSP, 8'h00, 8'h00, 16'h0010,
              8'h00};
    ht[4] = '{1'b1, 16'h6F3A, 3'd2, CFN_ST_LINEAR, 8'h0A, 8'h05, 16'h0032,
              8'h00};
    ht[5] = '{1'b1, 16'h6F3B, 3'd2, CFN_ST_CYCLIC, 8'h08, 8'h04, 16'h0020,
              8'h03};
    ht[6] = '{1'b1, 16'h6F40, 3'd1, CFN_ST_TRANSP, 8'h00, 8'h00, 16'h0004,
              8'h00};
    tf[7] = 16'h6F99;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    admin_i <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      tf[k] = ht[k].fid;
      tp[k] = int'(ht[k].parent);
      td[k] = ht[k].kind == CFN_ST_DIR;
      load(k, ht[k], 1'b0);
    end
    load(7, ht[4], 1'b1);
    tmp = ht[2];
    tmp.parent = 3'd2;
    load(7, tmp, 1'b1);
    tmp.fid = CFN_SECOND_ID;
    tmp.parent = 3'd1;
    load(7, tmp, 1'b1);
    admin_i <= 1'b0;
    tmp = ht[6];
    tmp.fid = 16'h6F41;
    load(7, tmp, 1'b1);
    atr();
    term.dir_n = CFN_ROOT_ID;
    term.fire(6);
    `CHK(app_ok_o, 1'b1)
    term.dir_n = CFN_PRIMARY_ID;
    term.fire(6);
    `CHK(app_ok_o, 1'b0)
    sel(16'h6F3A);
    sel(16'h2F05);
    bin(16'h0000, 8'h10);
    bin(16'h0010, 8'h01);
    repeat (20) bin(16'($unsigned($random(seed)) % 21),
                    8'(1 + $unsigned($random(seed)) % 8));
    term.fire(7);
    `CHK(hdr_o.fid, 16'h2F05)
    `CHK(hdr_o.body_len, 16'h0010)
    sel(CFN_PRIMARY_ID);
    sel(16'h6F3A);
    `CHK(rec_ptr_o, CFN_PTR_NONE)
    rec(CFN_M_NEXT, 1'b0, 8'h00, 1'b1, 8'h01);
    rec(CFN_M_PREV, 1'b0, 8'h00, 1'b0, 8'h00);
    rec(CFN_M_NEXT, 1'b0, 8'h00, 1'b1, 8'h02);
    term.fire(2);
    `CHK(rec_target_o, 8'h03)
    term.fire(4);
    `CHK(rec_ptr_o, 8'h02)
    term.rq_n = '{CFN_M_CURR, 1'b0, 8'h00};
    term.fire(2);
    term.fire(2);
    `CHK(rec_err_o, 1'b1)
    term.fire(3);
    rec(CFN_M_ABS, 1'b0, 8'h05, 1'b1, 8'h05);
    `CHK(rec_offset_o, 16'h0028)
    rec(CFN_M_ABS, 1'b0, 8'h06, 1'b0, 8'h00);
    rec(CFN_M_NEXT, 1'b0, 8'h00, 1'b0, 8'h00);
    rec(CFN_M_SNEXT, 1'b0, 8'h00, 1'b0, 8'h00);
    rec(CFN_M_SFIRST, 1'b0, 8'h00, 1'b1, 8'h01);
    rec(CFN_M_SPREV, 1'b0, 8'h00, 1'b0, 8'h00);
    rec(CFN_M_SLAST, 1'b0, 8'h00, 1'b1, 8'h05);
    sel(16'h6F3A);
    rec(CFN_M_PREV, 1'b0, 8'h00, 1'b1, 8'h05);
    sel(16'h6F3B);
    `CHK(rec_ptr_o, CFN_REC_FIRST)
    rec(CFN_M_PREV, 1'b0, 8'h00, 1'b1, 8'h04);
    rec(CFN_M_NEXT, 1'b0, 8'h00, 1'b1, 8'h01);
    rec(CFN_M_NEXT, 1'b1, 8'h00, 1'b0, 8'h00);
    rec(CFN_M_PREV, 1'b1, 8'h00, 1'b1, 8'h01);
    repeat (60) sel(tf[$unsigned($random(seed)) % 8]);
    atr();
    tally_and_finish;
  end
endmodule // tb_card_file_system_navigator
